/* design/bju_pkg.sv */
package bju_pkg;

  // control-transfer operations handed over by the core decoder
  typedef enum logic [3:0] {
    OP_BRANCH = 4'h0,
    OP_JUMP_ACC = 4'h1,
    OP_JUMP_ABS = 4'h2,
    OP_JUMP_REG = 4'h3,
    OP_JUMP_MEM = 4'h4,
    OP_JUMPX_REG = 4'h5,
    OP_JUMPX_MEM = 4'h6,
    OP_JUMPX_ABS = 4'h7,
    OP_CALL_REG = 4'h8,
    OP_CALL_MEM = 4'h9,
    OP_CALL_ABS = 4'hA,
    OP_CALLX_REG = 4'hB,
    OP_CALLX_MEM = 4'hC,
    OP_CALLX_ABS = 4'hD
  } bju_op_t;

  // branch conditions of the relative branch
  typedef enum logic [4:0] {
    COND_ZERO = 5'h00,
    COND_NONZERO = 5'h01,
    COND_CARRY = 5'h02,
    COND_NO_CARRY = 5'h03,
    COND_NEGATIVE = 5'h04,
    COND_POSITIVE = 5'h05,
    COND_OVERFLOW = 5'h06,
    COND_NO_OVERFLOW = 5'h07,
    COND_STICKY = 5'h08,
    COND_NO_STICKY = 5'h09,
    COND_SIGNED_LESS = 5'h0A,
    COND_SIGNED_GREATER_EQUAL = 5'h0B,
    COND_SIGNED_LESS_EQUAL = 5'h0C,
    COND_SIGNED_GREATER = 5'h0D,
    COND_UNSIGNED_LOWER_SAME = 5'h0E,
    COND_UNSIGNED_HIGHER = 5'h0F,
    COND_ALWAYS = 5'h10
  } bju_cond_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } bju_state_t;

  typedef struct packed {
    logic t;
    logic n;
    logic z;
    logic v;
    logic c;
  } bju_flags_t;

  typedef struct packed {
    bju_op_t op;
    bju_cond_t cond;
    logic [7:0] rel;
    logic [23:0] imm;
    logic [15:0] acc_lo;
    logic [15:0] reg_lo;
    logic [15:0] reg_hi;
    logic [23:0] eam;
    logic [2:0] len;
    logic [3:0] corr;
  } bju_issue_t;

  // cycle counts per instruction form
  localparam logic [4:0] CYC_BR_TAKEN = 5'h03;
  localparam logic [4:0] CYC_BR_FALL = 5'h02;
  localparam logic [4:0] CYC_JUMP_ACC = 5'h02;
  localparam logic [4:0] CYC_JUMP_ABS = 5'h02;
  localparam logic [4:0] CYC_JUMP_REG = 5'h03;
  localparam logic [4:0] CYC_JUMP_MEM = 5'h04;
  localparam logic [4:0] CYC_JUMPX_REG = 5'h03;
  localparam logic [4:0] CYC_JUMPX_MEM = 5'h04;
  localparam logic [4:0] CYC_JUMPX_ABS = 5'h03;
  localparam logic [4:0] CYC_CALL_REG = 5'h04;
  localparam logic [4:0] CYC_CALL_MEM = 5'h05;
  localparam logic [4:0] CYC_CALL_ABS = 5'h05;
  localparam logic [4:0] CYC_CALLX_REG = 5'h07;
  localparam logic [4:0] CYC_CALLX_MEM = 5'h08;
  localparam logic [4:0] CYC_CALLX_ABS = 5'h07;

  // relative branches count from the byte after the two-byte opcode
  localparam logic [15:0] BR_LEN = 16'h0002;

  // register map
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_TARGET = 12'h008;
  localparam logic [11:0] REG_TAKEN_CNT = 12'h00C;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_TAKEN_BIT = 1;

endpackage

/* design/bju_cond.sv */
module bju_cond (
  input wire bju_pkg::bju_cond_t cond_i,
  input wire bju_pkg::bju_flags_t flags_i,
  output logic take_o
);

  wire vxn = flags_i.v ^ flags_i.n;
  wire cz = flags_i.c | flags_i.z;

  always_comb begin
    take_o = 1'b0;
    unique case (cond_i)
      bju_pkg::COND_ZERO: take_o = flags_i.z;
      bju_pkg::COND_NONZERO: take_o = ~flags_i.z;
      bju_pkg::COND_CARRY: take_o = flags_i.c;
      bju_pkg::COND_NO_CARRY: take_o = ~flags_i.c;
      bju_pkg::COND_NEGATIVE: take_o = flags_i.n;
      bju_pkg::COND_POSITIVE: take_o = ~flags_i.n;
      bju_pkg::COND_OVERFLOW: take_o = flags_i.v;
      bju_pkg::COND_NO_OVERFLOW: take_o = ~flags_i.v;
      bju_pkg::COND_STICKY: take_o = flags_i.t;
      bju_pkg::COND_NO_STICKY: take_o = ~flags_i.t;
      bju_pkg::COND_SIGNED_LESS: take_o = vxn;
      bju_pkg::COND_SIGNED_GREATER_EQUAL: take_o = ~vxn;
      bju_pkg::COND_SIGNED_LESS_EQUAL: take_o = vxn | flags_i.z;
      bju_pkg::COND_SIGNED_GREATER: take_o = ~(vxn | flags_i.z);
      bju_pkg::COND_UNSIGNED_LOWER_SAME: take_o = cz;
      bju_pkg::COND_UNSIGNED_HIGHER: take_o = ~cz;
      bju_pkg::COND_ALWAYS: take_o = 1'b1;
      default: take_o = 1'b0;
    endcase
  end

endmodule

/* design/bju_unit.sv */
module bju_unit #(
  parameter int unsigned APB_AW = 12
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic issue_valid_i,
  input wire bju_pkg::bju_issue_t issue_i,
  output logic issue_ready_o,
  input wire bju_pkg::bju_flags_t flags_i,
  input wire logic [15:0] pc_i,
  input wire logic [7:0] bank_i,
  input wire logic [23:0] sp_i,
  output logic done_o,
  output logic [15:0] new_pc_o,
  output logic [7:0] new_bank_o,
  output logic [2:0] sp_delta_o,
  output logic flags_we_o,
  output logic psw_we_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [23:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i
);

  generate
    if (APB_AW < 4 || APB_AW > 32) begin : g_bad_aw
      $error("APB address width must lie between 4 and 32");
    end
  endgenerate

  // cycle count of a non-branch form, memory forms add the correction
  function automatic logic [4:0] op_cycles(input bju_pkg::bju_op_t op,
                                           input logic [3:0] corr);
    logic [4:0] c;
    c = 5'h00;
    unique case (op)
      bju_pkg::OP_BRANCH: c = bju_pkg::CYC_BR_FALL;
      bju_pkg::OP_JUMP_ACC: c = bju_pkg::CYC_JUMP_ACC;
      bju_pkg::OP_JUMP_ABS: c = bju_pkg::CYC_JUMP_ABS;
      bju_pkg::OP_JUMP_REG: c = bju_pkg::CYC_JUMP_REG;
      bju_pkg::OP_JUMP_MEM: c = bju_pkg::CYC_JUMP_MEM + {1'b0, corr};
      bju_pkg::OP_JUMPX_REG: c = bju_pkg::CYC_JUMPX_REG;
      bju_pkg::OP_JUMPX_MEM: c = bju_pkg::CYC_JUMPX_MEM + {1'b0, corr};
      bju_pkg::OP_JUMPX_ABS: c = bju_pkg::CYC_JUMPX_ABS;
      bju_pkg::OP_CALL_REG: c = bju_pkg::CYC_CALL_REG;
      bju_pkg::OP_CALL_MEM: c = bju_pkg::CYC_CALL_MEM + {1'b0, corr};
      bju_pkg::OP_CALL_ABS: c = bju_pkg::CYC_CALL_ABS;
      bju_pkg::OP_CALLX_REG: c = bju_pkg::CYC_CALLX_REG;
      bju_pkg::OP_CALLX_MEM: c = bju_pkg::CYC_CALLX_MEM + {1'b0, corr};
      bju_pkg::OP_CALLX_ABS: c = bju_pkg::CYC_CALLX_ABS;
      default: c = bju_pkg::CYC_BR_FALL;
    endcase
    return c;
  endfunction

  // words pushed as return address
  function automatic logic [1:0] op_pushes(input bju_pkg::bju_op_t op);
    logic [1:0] n;
    n = 2'h0;
    if (op == bju_pkg::OP_CALL_REG || op == bju_pkg::OP_CALL_MEM ||
        op == bju_pkg::OP_CALL_ABS) begin
      n = 2'h1;
    end else if (op == bju_pkg::OP_CALLX_REG ||
                 op == bju_pkg::OP_CALLX_MEM ||
                 op == bju_pkg::OP_CALLX_ABS) begin
      n = 2'h2;
    end
    return n;
  endfunction

  // words read from the memory operand
  function automatic logic [1:0] op_reads(input bju_pkg::bju_op_t op);
    logic [1:0] n;
    n = 2'h0;
    if (op == bju_pkg::OP_JUMP_MEM || op == bju_pkg::OP_CALL_MEM) begin
      n = 2'h1;
    end else if (op == bju_pkg::OP_JUMPX_MEM ||
                 op == bju_pkg::OP_CALLX_MEM) begin
      n = 2'h2;
    end
    return n;
  endfunction

  // pushes come first, then reads; stack grows down by words
  function automatic logic [23:0] step_addr(input logic [2:0] s,
                                            input logic [1:0] npush,
                                            input logic [23:0] sp,
                                            input logic [23:0] eam);
    logic [23:0] a;
    logic [2:0] r;
    a = 24'h000000;
    r = s - {1'b0, npush};
    if (s < {1'b0, npush}) begin
      a = sp - {20'h00000, s + 3'h1, 1'b0};
    end else begin
      a = eam + {20'h00000, r, 1'b0};
    end
    return a;
  endfunction

  // long return: bank word at the higher address, pc word below it
  function automatic logic [15:0] step_wdata(input logic [2:0] s,
                                             input logic [1:0] npush,
                                             input logic [15:0] rpc,
                                             input logic [7:0] rbank);
    logic [15:0] d;
    d = rpc;
    if (npush == 2'h2 && s == 3'h0) begin
      d = {8'h00, rbank};
    end
    return d;
  endfunction

  function automatic logic [15:0] sext8(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction

  bju_pkg::bju_state_t state_q, state_d;
  bju_pkg::bju_issue_t iss_q;
  logic [4:0] cyc_q, total_q;
  logic [2:0] step_q, nsteps_q;
  logic [1:0] npush_q;
  logic [23:0] sp_q;
  logic [15:0] tgt_pc_q, ret_pc_q;
  logic [7:0] tgt_bank_q, ret_bank_q;
  logic taken_q;
  logic [23:0] mem_addr_q;
  logic [15:0] mem_wdata_q;
  logic mem_we_q;
  logic [31:0] ctrl_q, taken_cnt_q, prdata_q;

  wire take;
  bju_cond u_cond (
    .cond_i(issue_i.cond),
    .flags_i(flags_i),
    .take_o(take)
  );

  // issue side decode
  wire idle = (state_q == bju_pkg::ST_IDLE);
  wire busy = (state_q == bju_pkg::ST_BUSY);
  wire accept = issue_valid_i & issue_ready_o;
  wire is_branch = (issue_i.op == bju_pkg::OP_BRANCH);
  wire issue_take = is_branch ? take : 1'b1;
  wire [15:0] br_base = pc_i + bju_pkg::BR_LEN;
  wire [15:0] br_tgt = br_base + sext8(issue_i.rel);
  wire [15:0] ret_pc = pc_i + {13'h0000, issue_i.len};
  wire [4:0] br_cyc = take ? bju_pkg::CYC_BR_TAKEN :
                      bju_pkg::CYC_BR_FALL;
  wire [4:0] issue_cyc = is_branch ? br_cyc :
                         op_cycles(issue_i.op, issue_i.corr);
  wire [1:0] issue_push = op_pushes(issue_i.op);
  wire [2:0] issue_steps = {1'b0, issue_push} + {1'b0, op_reads(issue_i.op)};

  logic [15:0] issue_pc;
  logic [7:0] issue_bank;
  always_comb begin
    issue_pc = br_base;
    issue_bank = bank_i;
    unique case (issue_i.op)
      bju_pkg::OP_BRANCH: issue_pc = take ? br_tgt : br_base;
      bju_pkg::OP_JUMP_ACC: issue_pc = issue_i.acc_lo;
      bju_pkg::OP_JUMP_ABS, bju_pkg::OP_CALL_ABS: begin
        issue_pc = issue_i.imm[15:0];
      end
      bju_pkg::OP_JUMP_REG, bju_pkg::OP_CALL_REG: begin
        issue_pc = issue_i.reg_lo;
      end
      bju_pkg::OP_JUMPX_REG, bju_pkg::OP_CALLX_REG: begin
        issue_pc = issue_i.reg_lo;
        issue_bank = issue_i.reg_hi[7:0];
      end
      bju_pkg::OP_JUMPX_ABS, bju_pkg::OP_CALLX_ABS: begin
        issue_pc = issue_i.imm[15:0];
        issue_bank = issue_i.imm[23:16];
      end
      default: issue_pc = br_base;
    endcase
  end

  // sequencing while busy
  wire mem_pending = busy & (step_q < nsteps_q);
  wire mem_fire = mem_pending & mem_ack_i;
  wire [2:0] step_nx = step_q + 3'h1;
  wire [2:0] read_idx = step_q - {1'b0, npush_q};
  wire last_cyc = (cyc_q + 5'h01) >= total_q;
  wire finish = busy & last_cyc & ~mem_pending;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      bju_pkg::ST_IDLE: if (accept) state_d = bju_pkg::ST_BUSY;
      bju_pkg::ST_BUSY: if (finish) state_d = bju_pkg::ST_IDLE;
      default: state_d = bju_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state_q <= bju_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      iss_q <= '0;
      cyc_q <= 5'h00;
      total_q <= 5'h00;
      npush_q <= 2'h0;
      nsteps_q <= 3'h0;
      sp_q <= 24'h000000;
      ret_pc_q <= 16'h0000;
      ret_bank_q <= 8'h00;
      taken_q <= 1'b0;
    end else if (accept) begin
      iss_q <= issue_i;
      cyc_q <= 5'h01;
      total_q <= issue_cyc;
      npush_q <= issue_push;
      nsteps_q <= issue_steps;
      sp_q <= sp_i;
      ret_pc_q <= ret_pc;
      ret_bank_q <= bank_i;
      taken_q <= issue_take;
    end else if (busy && !last_cyc) begin
      cyc_q <= cyc_q + 5'h01;
    end
  end

  // step counter and registered memory request fields
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      step_q <= 3'h0;
      mem_addr_q <= 24'h000000;
      mem_wdata_q <= 16'h0000;
      mem_we_q <= 1'b0;
    end else if (accept) begin
      step_q <= 3'h0;
      mem_addr_q <= step_addr(3'h0, issue_push, sp_i, issue_i.eam);
      mem_wdata_q <= step_wdata(3'h0, issue_push, ret_pc, bank_i);
      mem_we_q <= (issue_push != 2'h0);
    end else if (mem_fire) begin
      step_q <= step_nx;
      mem_addr_q <= step_addr(step_nx, npush_q, sp_q, iss_q.eam);
      mem_wdata_q <= step_wdata(step_nx, npush_q, ret_pc_q, ret_bank_q);
      mem_we_q <= (step_nx < {1'b0, npush_q});
    end
  end

  // target: set at issue, memory forms overwrite with the words read
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      tgt_pc_q <= 16'h0000;
      tgt_bank_q <= 8'h00;
    end else if (accept) begin
      tgt_pc_q <= issue_pc;
      tgt_bank_q <= issue_bank;
    end else if (mem_fire && !mem_we_q) begin
      if (read_idx == 3'h0) begin
        tgt_pc_q <= mem_rdata_i;
      end else begin
        tgt_bank_q <= mem_rdata_i[7:0];
      end
    end
  end

  assign issue_ready_o = idle & ctrl_q[bju_pkg::CTRL_EN_BIT];
  assign done_o = finish;
  assign new_pc_o = tgt_pc_q;
  assign new_bank_o = tgt_bank_q;
  assign sp_delta_o = {npush_q, 1'b0};
  assign flags_we_o = 1'b0;
  assign psw_we_o = 1'b0;
  assign mem_req_o = mem_pending;
  assign mem_we_o = mem_we_q;
  assign mem_addr_o = mem_addr_q;
  assign mem_wdata_o = mem_wdata_q;

  // APB slave, zero wait states
  wire [11:0] addr12 = 12'(paddr_i);
  wire apb_setup = psel_i & ~penable_i;
  wire apb_access = psel_i & penable_i;
  wire hit_ctrl = (addr12 == bju_pkg::REG_CTRL);
  wire hit_status = (addr12 == bju_pkg::REG_STATUS);
  wire hit_target = (addr12 == bju_pkg::REG_TARGET);
  wire hit_cnt = (addr12 == bju_pkg::REG_TAKEN_CNT);
  wire mapped = hit_ctrl | hit_status | hit_target | hit_cnt;
  wire apb_wr = apb_access & pwrite_i & mapped;
  wire cnt_clr = apb_wr & hit_cnt;
  wire cnt_inc = finish & taken_q;
  wire [31:0] status_word = {30'h00000000, taken_q, busy};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_q :
                       hit_status ? status_word :
                       hit_target ? {8'h00, tgt_bank_q, tgt_pc_q} :
                       hit_cnt ? taken_cnt_q : 32'h00000000;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      ctrl_q <= bju_pkg::CTRL_RST;
    end else if (apb_wr && hit_ctrl) begin
      ctrl_q <= {31'h00000000, pwdata_i[bju_pkg::CTRL_EN_BIT]};
    end
  end

  // an increment in the clearing cycle is kept
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      taken_cnt_q <= 32'h00000000;
    end else if (cnt_clr) begin
      taken_cnt_q <= {31'h00000000, cnt_inc};
    end else if (cnt_inc) begin
      taken_cnt_q <= taken_cnt_q + 32'h00000001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      prdata_q <= 32'h00000000;
    end else if (apb_setup) begin
      prdata_q <= pwrite_i ? 32'h00000000 : rd_mux;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = 1'b1;
  assign pslverr_o = apb_access & ~mapped;

endmodule

/* verif/bju_unit_monitor.sv */
module bju_unit_monitor (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic issue_valid_i,
  input wire bju_pkg::bju_issue_t issue_i,
  input wire logic issue_ready_o,
  input wire logic [15:0] pc_i,
  input wire logic [7:0] bank_i,
  input wire logic [23:0] sp_i,
  input wire logic done_o,
  input wire logic [15:0] new_pc_o,
  input wire logic [7:0] new_bank_o,
  input wire logic flags_we_o,
  input wire logic psw_we_o,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [23:0] mem_addr_o,
  input wire logic [15:0] mem_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  wire logic go_w;
  wire bju_pkg::bju_op_t op_w;
  assign go_w = issue_valid_i && issue_ready_o;
  assign op_w = issue_i.op;
  property p_jump_acc;
    go_w && op_w == bju_pkg::OP_JUMP_ACC |-> ##1 done_o &&
      new_pc_o == $past(issue_i.acc_lo) && new_bank_o == $past(bank_i);
  endproperty
  a_jump_acc: assert property (p_jump_acc)
    else $error("accumulator jump wrong");
  property p_jump_abs;
    go_w && op_w == bju_pkg::OP_JUMP_ABS |-> ##1 done_o &&
      new_pc_o == 16'($past(issue_i.imm)) && new_bank_o == $past(bank_i);
  endproperty
  a_jump_abs: assert property (p_jump_abs)
    else $error("absolute jump wrong");
  property p_jumpx_reg;
    go_w && op_w == bju_pkg::OP_JUMPX_REG |-> ##2 done_o &&
      new_pc_o == $past(issue_i.reg_lo, 2) &&
      new_bank_o == 8'($past(issue_i.reg_hi, 2));
  endproperty
  a_jumpx_reg: assert property (p_jumpx_reg)
    else $error("cross-bank register jump wrong");
  property p_jumpx_abs;
    go_w && op_w == bju_pkg::OP_JUMPX_ABS |-> ##2 done_o &&
      {new_bank_o, new_pc_o} == $past(issue_i.imm, 2);
  endproperty
  a_jumpx_abs: assert property (p_jumpx_abs)
    else $error("24-bit jump wrong");
  property p_branch;
    go_w && op_w == bju_pkg::OP_BRANCH |-> ##1
      (done_o && new_pc_o == $past(pc_i) + 16'h0002) or (!done_o ##1 done_o);
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch timing wrong");
  property p_no_psw;
    !flags_we_o && !psw_we_o;
  endproperty
  a_no_psw: assert property (p_no_psw)
    else $error("flags written");
  property p_call_push;
    go_w && op_w == bju_pkg::OP_CALL_ABS |-> ##1 mem_req_o && mem_we_o &&
      mem_addr_o == $past(sp_i) - 24'h000002 &&
      mem_wdata_o == $past(pc_i) + {13'h0000, $past(issue_i.len)};
  endproperty
  a_call_push: assert property (p_call_push)
    else $error("call push wrong");
  property p_callx_push;
    go_w && op_w == bju_pkg::OP_CALLX_ABS |-> ##1 mem_req_o && mem_we_o &&
      mem_addr_o == $past(sp_i) - 24'h000002 &&
      mem_wdata_o == {8'h00, $past(bank_i)};
  endproperty
  a_callx_push: assert property (p_callx_push)
    else $error("long call push wrong");
  c_taken: cover property (go_w && op_w == bju_pkg::OP_BRANCH ##2 done_o);
  c_fall: cover property (go_w && op_w == bju_pkg::OP_BRANCH ##1 done_o);
  c_callx: cover property (go_w && op_w == bju_pkg::OP_CALLX_MEM);
endmodule

bind bju_unit bju_unit_monitor mon (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
  .issue_valid_i(issue_valid_i), .issue_i(issue_i),
  .issue_ready_o(issue_ready_o), .pc_i(pc_i), .bank_i(bank_i), .sp_i(sp_i),
  .done_o(done_o), .new_pc_o(new_pc_o), .new_bank_o(new_bank_o),
  .flags_we_o(flags_we_o), .psw_we_o(psw_we_o), .mem_req_o(mem_req_o),
  .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o));

/* verif/bju_mem_model.sv */
module bju_mem_model (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic slow_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [23:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic ack_o,
  output logic [15:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [512];
  logic [24:0] log_a [$];
  logic [15:0] log_d [$];
  logic [1:0] wait_q = 2'h0;
  logic [15:0] junk_q = 16'hA5C3;
  initial begin
    mem[9'h020] = 16'h6B2C;
    mem[9'h021] = 16'h0077;
  end
  // slow answers hold each step two extra cycles
  assign ack_o = req_i && (!slow_i || wait_q == 2'h2);
  // read data only while answering, else a toggling pattern
  assign rdata_o = (ack_o && !we_i) ? mem[addr_i[9:1]] : junk_q;
  always @(posedge ref_clk_i) begin
    junk_q <= ~junk_q;
    wait_q <= (nrst_i && req_i && !ack_o) ? wait_q + 2'h1 : 2'h0;
    if (nrst_i && ack_o) begin
      log_a.push_back({we_i, addr_i});
      log_d.push_back(wdata_i);
      if (we_i) mem[addr_i[9:1]] <= wdata_i;
    end
  end
endmodule

/* verif/tb_branch_jump_call_unit.sv */
module tb_branch_jump_call_unit;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    bju_pkg::bju_op_t op;
    logic [4:0] cyc;
    logic [2:0] spd;
    logic [1:0] src;
    logic xb;
  } bju_row_t;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic issue_valid_i = 1'b0;
  bju_pkg::bju_issue_t issue_i = '{bju_pkg::OP_BRANCH, bju_pkg::COND_ZERO,
    8'h00, 24'h3C4A6E, 16'h1357, 16'h2468, 16'h00A5, 24'h000040, 3'h3, 4'h1};
  bju_pkg::bju_flags_t flags_i = 5'h00;
  logic [15:0] pc_i = 16'h8000;
  logic [7:0] bank_i = 8'h12;
  logic [23:0] sp_i = 24'h000100;
  logic slow = 1'b0;
  logic [31:0] prdata_o, rd;
  logic pready_o, pslverr_o, issue_ready_o, done_o, flags_we_o, psw_we_o;
  logic mem_req_o, mem_we_o, mem_ack_i, err, t;
  logic [15:0] new_pc_o, mem_wdata_o, mem_rdata_i;
  logic [7:0] new_bank_o;
  logic [2:0] sp_delta_o;
  logic [23:0] mem_addr_o;
  int n_errors = 0;
  int compares = 0;
  int n, cnt;
  logic [15:0] tpc [4] = '{16'h1357, 16'h4A6E, 16'h2468, 16'h6B2C};
  logic [7:0] tbk [4] = '{8'h12, 8'h3C, 8'hA5, 8'h77};
  bju_row_t rows [13] = '{
    '{bju_pkg::OP_JUMP_ACC, 5'h02, 3'h0, 2'h0, 1'b0},
    '{bju_pkg::OP_JUMP_ABS, 5'h02, 3'h0, 2'h1, 1'b0},
    '{bju_pkg::OP_JUMP_REG, 5'h03, 3'h0, 2'h2, 1'b0},
    '{bju_pkg::OP_JUMP_MEM, 5'h05, 3'h0, 2'h3, 1'b0},
    '{bju_pkg::OP_JUMPX_REG, 5'h03, 3'h0, 2'h2, 1'b1},
    '{bju_pkg::OP_JUMPX_MEM, 5'h05, 3'h0, 2'h3, 1'b1},
    '{bju_pkg::OP_JUMPX_ABS, 5'h03, 3'h0, 2'h1, 1'b1},
    '{bju_pkg::OP_CALL_REG, 5'h04, 3'h2, 2'h2, 1'b0},
    '{bju_pkg::OP_CALL_MEM, 5'h06, 3'h2, 2'h3, 1'b0},
    '{bju_pkg::OP_CALL_ABS, 5'h05, 3'h2, 2'h1, 1'b0},
    '{bju_pkg::OP_CALLX_REG, 5'h07, 3'h4, 2'h2, 1'b1},
    '{bju_pkg::OP_CALLX_MEM, 5'h09, 3'h4, 2'h3, 1'b1},
    '{bju_pkg::OP_CALLX_ABS, 5'h07, 3'h4, 2'h1, 1'b1}};
  bju_unit dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .issue_valid_i(issue_valid_i), .issue_i(issue_i),
    .issue_ready_o(issue_ready_o), .flags_i(flags_i), .pc_i(pc_i),
    .bank_i(bank_i), .sp_i(sp_i), .done_o(done_o), .new_pc_o(new_pc_o),
    .new_bank_o(new_bank_o), .sp_delta_o(sp_delta_o),
    .flags_we_o(flags_we_o), .psw_we_o(psw_we_o), .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));
  bju_mem_model mem_m (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .slow_i(slow),
    .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
  always #12.5 ref_clk_i = ~ref_clk_i;
  task chk(input string w, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (e !== g) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task close_out;
    $display("counts: %0d compares, %0d mismatches", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task hang(input string w);
    chk(w, 1, 0);
    close_out();
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk_i);
      i++;
    end while (pready_o !== 1'b1 && i < 20);
    if (pready_o !== 1'b1) hang("pready");
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task run(input bju_pkg::bju_op_t op, input logic [4:0] c,
           input logic [4:0] f);
    int i;
    @(posedge ref_clk_i);
    issue_valid_i <= 1'b1;
    issue_i.op <= op;
    issue_i.cond <= bju_pkg::bju_cond_t'(c);
    issue_i.rel <= f[0] ? 8'h7F : 8'h80;
    flags_i <= f;
    i = 0;
    do begin
      @(posedge ref_clk_i);
      i++;
    end while (issue_ready_o !== 1'b1 && i < 20);
    if (issue_ready_o !== 1'b1) hang("issue ready");
    n = 1;
    issue_valid_i <= 1'b0;
    flags_i <= ~f;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 40);
    if (n >= 40) hang("done");
    chk("psw write", 2'b00, {flags_we_o, psw_we_o});
  endtask
  task do_row(input bju_row_t r, input logic timed);
    int k;
    mem_m.log_a.delete();
    mem_m.log_d.delete();
    run(r.op, 5'h00, 5'h00);
    if (timed) chk("cycles", r.cyc, n);
    chk("new pc", tpc[r.src], new_pc_o);
    chk("new bank", r.xb ? tbk[r.src] : 8'h12, new_bank_o);
    chk("sp delta", r.spd, sp_delta_o);
    chk("steps", r.spd / 2 + (r.src == 3 ? 1 + r.xb : 0),
      mem_m.log_a.size());
    for (k = 0; k < r.spd / 2; k++) begin
      chk("push addr", {1'b1, 24'h0000FE - 24'(2 * k)},
        mem_m.log_a[k]);
      chk("push data", (r.spd == 4 && k == 0) ?
        16'h0012 : 16'h8003, mem_m.log_d[k]);
    end
  endtask
  function automatic logic exp_take(input logic [4:0] c, input logic [4:0] f);
    logic ts, ng, z, v, cy, b;
    {ts, ng, z, v, cy} = f;
    case (c[3:1])
      3'h0: b = z;
      3'h1: b = cy;
      3'h2: b = ng;
      3'h3: b = v;
      3'h4: b = ts;
      3'h5: b = v ^ ng;
      3'h6: b = (v ^ ng) | z;
      default: b = cy | z;
    endcase
    return c[4] ? 1'b1 : b ^ c[0];
  endfunction
  initial begin
    repeat (20) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(negedge ref_clk_i);
    chk("reset outputs", 4'h9, {issue_ready_o, done_o, mem_req_o, pready_o});
    apb(1'b0, bju_pkg::REG_CTRL, 32'h0);
    chk("ctrl reset", 32'h0000_0001, rd);
    $display("test reset done");
    foreach (rows[i]) do_row(rows[i], 1'b1);
    apb(1'b0, bju_pkg::REG_TARGET, 32'h0);
    chk("target reg", 32'h003C_4A6E, rd);
    $display("test rows done");
    apb(1'b1, bju_pkg::REG_TAKEN_CNT, 32'h0);
    cnt = 0;
    for (int c = 0; c < 17; c++) begin
      for (int f = 0; f < 32; f++) begin
        run(bju_pkg::OP_BRANCH, 5'(c), 5'(f));
        t = exp_take(5'(c), 5'(f));
        cnt += t;
        chk("branch cycles", t ? 3 : 2, n);
        chk("branch pc",
          t ? (f[0] ? 16'h8081 : 16'h7F82) : 16'h8002, new_pc_o);
      end
    end
    apb(1'b0, bju_pkg::REG_TAKEN_CNT, 32'h0);
    chk("taken count", cnt, rd);
    apb(1'b0, bju_pkg::REG_STATUS, 32'h0);
    chk("status", 32'h0000_0002, rd);
    $display("test branches done");
    @(posedge ref_clk_i);
    slow <= 1'b1;
    do_row(rows[11], 1'b0);
    chk("slow longer", 1, n > 9);
    @(posedge ref_clk_i);
    slow <= 1'b0;
    $display("test slow memory done");
    apb(1'b1, bju_pkg::REG_CTRL, 32'h0);
    @(negedge ref_clk_i);
    chk("ready when off", 0, issue_ready_o);
    apb(1'b1, bju_pkg::REG_CTRL, 32'h0000_0001);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    $display("test registers done");
    @(posedge ref_clk_i);
    issue_valid_i <= 1'b1;
    @(posedge ref_clk_i);
    issue_valid_i <= 1'b0;
    @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    chk("busy before reset", 1, mem_req_o);
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(negedge ref_clk_i);
    chk("reset again", 4'h9, {issue_ready_o, done_o, mem_req_o, pready_o});
    chk("pc after reset", 16'h0000, new_pc_o);
    apb(1'b0, bju_pkg::REG_TAKEN_CNT, 32'h0);
    chk("count after reset", 0, rd);
    $display("test mid-run reset done");
    close_out();
  end
endmodule
